// File: rtl/fst_flash_dev.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// (RULE1) suspend during program sets program-suspended flag
// (RULE2) terminate during program sets program-error flag
// (RULE3) suspend during erase sets erase-suspended flag
// (RULE4) terminate during erase sets erase-error flag
// (RULE5) flags rise, busy falls after latency
// (RULE6) terminate beats unfinished suspend, no resume
// (RULE7) terminate ignored once suspend has completed
// (RULE8) host issues no program/erase while suspended
// (RULE9) host erases terminated region before reprogramming
// (RULE10) terminate ignored during non-volatile register writes
// (RULE11) resets deferred until non-volatile write finishes
// (RULE12) four 128-byte otp registers, first locked
// (RULE13) writing top byte locks register, sets field
// (RULE14) otp address: 2 select bits, 7 byte bits
// (RULE15) host holds sck constant during reset sequence
// (RULE16) cs rising samples si; 0101 triggers reset
// (RULE17) host drives si as cs falls
// (RULE18) any sck edge abandons reset sequence
// (RULE19) reset in ultra-deep power-down loses buffer
// (RULE20) other resets keep buffer, clear volatile state
// (RULE21) resets keep non-volatile status registers
// (RULE22) reset returns to single-line spi mode
// (RULE23) resume leaves error flags unchanged
// (RULE24) new erase/program clears matching error flag
module fst_flash_dev
  import fst_pkg::*;
#(
  parameter int PROG_CYCLES = fst_pkg::PROG_CYC,
  parameter int ERASE_CYCLES = fst_pkg::ERASE_CYC,
  parameter int NV_CYCLES = fst_pkg::NV_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial link
  fst_link_if.dev link,
  // reset pin
  input wire logic hw_reset_pin_n,
  // otp read port
  input wire logic [8:0] otp_rd_addr,
  output logic [7:0] otp_rd_data,
  // status
  output logic busy,
  output logic program_suspended_flag,
  output logic program_error_flag,
  output logic erase_suspended_flag,
  output logic erase_error_flag,
  output logic [2:0] otp_lock_field,
  output logic [7:0] nv_status,
  output logic quad_mode,
  output logic ultra_deep_power_down,
  output logic global_protect,
  output logic [7:0] buffer_byte,
  output logic buffer_valid,
  output logic reset_taken
);
  import fst_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisation and edges
  // ---------------------------------------------------------------
  logic [3:0] pin_s;
  logic cs_d_reg, sck_d_reg;
  logic cs_s, sck_s, si_s, hw_rst_s;
  logic cs_rise, cs_fall, sck_rise, sck_edge;

  fst_sync #(.W(4), .RST_VAL(4'h9)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .d({link.cs_n, link.sck, link.si, hw_reset_pin_n}),
    .q(pin_s)
  );

  assign cs_s = pin_s[3];
  assign sck_s = pin_s[2];
  assign si_s = pin_s[1]; // RULE17
  assign hw_rst_s = pin_s[0];

  // previous pin levels
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cs_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
    end else begin
      cs_d_reg <= cs_s;
      sck_d_reg <= sck_s;
    end
  end

  assign cs_rise = cs_s & ~cs_d_reg;
  assign cs_fall = ~cs_s & cs_d_reg;
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_edge = sck_s ^ sck_d_reg;

  // ---------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------
  logic [5:0] bit_cnt_reg;
  logic [7:0] sh_reg;
  logic sck_seen_reg;
  logic [7:0] fb_reg [0:4];

  // shift si on sck rising edges while selected
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bit_cnt_reg <= 6'h00;
      sh_reg <= 8'h00;
      sck_seen_reg <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_reg <= 6'h00;
      sck_seen_reg <= 1'b0;
    end else if (!cs_s) begin
      if (sck_edge) sck_seen_reg <= 1'b1;
      if (sck_rise) begin
        sh_reg <= {sh_reg[6:0], si_s};
        if (bit_cnt_reg != 6'h3f) bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  // store completed bytes: opcode, three address bytes, data
  always_ff @(posedge ref_clk) begin
    if (!cs_s && sck_rise && bit_cnt_reg[2:0] == 3'h7 && bit_cnt_reg[5:3] < 3'h5) begin
      fb_reg[bit_cnt_reg[5:3]] <= {sh_reg[6:0], si_s};
    end
  end

  logic frame_ok, cmd_go;
  logic [7:0] opc;
  assign frame_ok = cs_rise && bit_cnt_reg != 6'h00 && bit_cnt_reg[2:0] == 3'h0;
  assign opc = fb_reg[0];
  assign cmd_go = frame_ok & ~ultra_deep_power_down;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  fst_op_state_e state_reg;
  fst_op_kind_e kind_reg;
  logic [TMR_W-1:0] timer_reg, saved_reg;
  logic idle, susp_any, tmr_done, nv_busy;
  logic start_prog, start_erase, start_nv, resume_go, susp_cmd, term_cmd;
  logic op_done, sus_done, term_done, rst_do;

  assign idle = state_reg == OPS_IDLE;
  assign susp_any = program_suspended_flag | erase_suspended_flag;
  assign tmr_done = timer_reg == '0;
  assign nv_busy = state_reg == OPS_RUN && kind_reg == KIND_NV;
  assign start_prog = cmd_go && opc == OP_PROG && idle && !susp_any;
  assign start_erase = cmd_go && opc == OP_ERASE && idle && !susp_any;
  assign start_nv = cmd_go && (opc == OP_WRSR || opc == OP_OTP) && idle && !susp_any;
  assign resume_go = cmd_go && opc == OP_RESUME && idle && susp_any;
  assign susp_cmd = cmd_go && opc == OP_SUSP && kind_reg != KIND_NV;
  assign term_cmd = cmd_go && opc == OP_TERM && kind_reg != KIND_NV; // RULE10
  assign op_done = state_reg == OPS_RUN && tmr_done;
  assign sus_done = state_reg == OPS_SUSPENDING && tmr_done && !term_cmd;
  assign term_done = state_reg == OPS_TERMINATING && tmr_done;

  // ---------------------------------------------------------------
  // self-timed operation sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n || rst_do) begin
      state_reg <= OPS_IDLE;
      kind_reg <= KIND_PROG;
      timer_reg <= '0;
      saved_reg <= '0;
      busy <= 1'b0;
    end else begin
      unique case (state_reg)
        OPS_IDLE: begin
          busy <= 1'b0;
          if (start_prog || start_erase || start_nv) begin
            state_reg <= OPS_RUN;
            busy <= 1'b1;
            kind_reg <= start_prog ? KIND_PROG : (start_erase ? KIND_ERASE : KIND_NV);
            timer_reg <= start_prog ? TMR_W'(PROG_CYCLES - 1)
                       : (start_erase ? TMR_W'(ERASE_CYCLES - 1) : TMR_W'(NV_CYCLES - 1));
          end else if (resume_go) begin
            state_reg <= OPS_RUN;
            busy <= 1'b1;
            timer_reg <= saved_reg;
          end
          // terminate after a finished suspend falls through here unheard: RULE7
        end
        OPS_RUN: begin
          if (op_done) begin
            state_reg <= OPS_IDLE;
            busy <= 1'b0;
          end else if (term_cmd) begin
            state_reg <= OPS_TERMINATING; // RULE2 RULE4
            timer_reg <= TMR_W'(TERM_CYC - 1);
          end else if (susp_cmd) begin
            state_reg <= OPS_SUSPENDING; // RULE1 RULE3
            saved_reg <= timer_reg;
            timer_reg <= TMR_W'(SUS_CYC - 1);
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        OPS_SUSPENDING: begin
          if (term_cmd) begin
            state_reg <= OPS_TERMINATING; // RULE6
            timer_reg <= TMR_W'(TERM_CYC - 1);
          end else if (tmr_done) begin
            state_reg <= OPS_IDLE; // RULE5
            busy <= 1'b0;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        OPS_TERMINATING: begin
          if (tmr_done) begin
            state_reg <= OPS_IDLE; // RULE5
            busy <= 1'b0;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // suspend flags, cleared by resume
  always_ff @(posedge ref_clk) begin
    if (!reset_n || rst_do) begin
      program_suspended_flag <= 1'b0;
      erase_suspended_flag <= 1'b0;
    end else begin
      if (resume_go) begin
        program_suspended_flag <= 1'b0;
        erase_suspended_flag <= 1'b0;
      end
      if (sus_done && kind_reg == KIND_PROG) program_suspended_flag <= 1'b1; // RULE1 RULE5
      if (sus_done && kind_reg == KIND_ERASE) erase_suspended_flag <= 1'b1; // RULE3 RULE5
    end
  end

  // error flags: program flag cleared on new program or nv write, erase flag on new erase; untouched by resume
  always_ff @(posedge ref_clk) begin
    if (!reset_n || rst_do) begin
      program_error_flag <= 1'b0;
      erase_error_flag <= 1'b0;
    end else begin
      if (start_prog || start_nv) program_error_flag <= 1'b0; // RULE24 RULE23
      if (start_erase) erase_error_flag <= 1'b0; // RULE24
      if (term_done && kind_reg == KIND_PROG) program_error_flag <= 1'b1; // RULE2 RULE6
      if (term_done && kind_reg == KIND_ERASE) erase_error_flag <= 1'b1; // RULE4 RULE6
    end
  end

  // ---------------------------------------------------------------
  // non-volatile registers and otp
  // ---------------------------------------------------------------
  logic nv_is_otp_reg;
  logic [8:0] nv_addr_reg;
  logic [7:0] nv_data_reg;
  logic [7:0] otp_mem [0:511];
  logic otp_wr_ok;

  // latch target of a non-volatile write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      nv_is_otp_reg <= 1'b0;
      nv_addr_reg <= 9'h000;
      nv_data_reg <= 8'h00;
    end else if (start_nv) begin
      nv_is_otp_reg <= opc == OP_OTP;
      nv_addr_reg <= {fb_reg[2][0], fb_reg[3]}; // RULE14
      nv_data_reg <= opc == OP_OTP ? fb_reg[4] : fb_reg[1];
    end
  end

  // register 0 is factory-locked
  assign otp_wr_ok = nv_addr_reg[8:7] != 2'h0 && !otp_lock_field[nv_addr_reg[8:7] - 2'h1]; // RULE12

  // otp array write and read
  always_ff @(posedge ref_clk) begin
    if (op_done && kind_reg == KIND_NV && nv_is_otp_reg && otp_wr_ok) begin
      otp_mem[nv_addr_reg] <= nv_data_reg; // RULE12
    end
    otp_rd_data <= otp_mem[otp_rd_addr];
  end

  // lock field and status write survive device resets
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      otp_lock_field <= 3'h0;
      nv_status <= NV_STATUS_DEFAULT;
    end else if (op_done && kind_reg == KIND_NV) begin // RULE21
      if (!nv_is_otp_reg) nv_status <= nv_data_reg;
      else if (otp_wr_ok && nv_addr_reg[6:0] == OTP_LAST_BYTE) begin
        otp_lock_field[nv_addr_reg[8:7] - 2'h1] <= 1'b1; // RULE13
      end
    end
  end

  // ---------------------------------------------------------------
  // reset sources: chip-select sequence, software, pin, wake
  // ---------------------------------------------------------------
  logic [3:0] jbits_reg;
  logic [2:0] jcnt_reg;
  logic rsten_reg, rst_pend_reg, jedec_req;

  assign jedec_req = cs_rise && !sck_seen_reg && jcnt_reg >= 3'h3
                     && {jbits_reg[2:0], si_s} == JEDEC_PATTERN; // RULE16

  // sample si on each sck-free cs pulse
  always_ff @(posedge ref_clk) begin
    if (!reset_n || jedec_req) begin
      jbits_reg <= 4'h0;
      jcnt_reg <= 3'h0;
    end else if (sck_edge || (cs_rise && sck_seen_reg)) begin
      jcnt_reg <= 3'h0; // RULE18
    end else if (cs_rise) begin
      jbits_reg <= {jbits_reg[2:0], si_s}; // RULE16
      if (jcnt_reg != 3'h4) jcnt_reg <= jcnt_reg + 3'h1;
    end
  end

  // reset enable arms only the next command
  always_ff @(posedge ref_clk) begin
    if (!reset_n || rst_do) rsten_reg <= 1'b0;
    else if (cmd_go) rsten_reg <= opc == OP_RSTEN;
  end

  // pending reset waits out non-volatile writes
  assign rst_do = rst_pend_reg && !nv_busy; // RULE11
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rst_pend_reg <= 1'b0;
    end else if (jedec_req || !hw_rst_s || (frame_ok && ultra_deep_power_down && opc == OP_WAKE)
                 || (cmd_go && opc == OP_RST && rsten_reg)) begin
      rst_pend_reg <= 1'b1; // RULE11
    end else if (rst_do) begin
      rst_pend_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // volatile modes and buffer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n || rst_do) begin
      quad_mode <= 1'b0; // RULE22
      global_protect <= PROTECT_DEFAULT; // RULE19 RULE20
      ultra_deep_power_down <= 1'b0;
    end else if (cmd_go) begin
      if (opc == OP_QUAD) quad_mode <= 1'b1;
      if (opc == OP_GLOCK) global_protect <= 1'b1;
      if (opc == OP_GUNLOCK) global_protect <= 1'b0;
      if (opc == OP_DEEP && idle) ultra_deep_power_down <= 1'b1;
    end
  end

  // buffer kept across reset unless powered down
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buffer_byte <= 8'h00;
      buffer_valid <= 1'b0;
    end else if (rst_do) begin
      if (ultra_deep_power_down) buffer_valid <= 1'b0; // RULE19
    end else if (cmd_go && opc == OP_BUFWR) begin
      buffer_byte <= fb_reg[1]; // RULE20
      buffer_valid <= 1'b1;
    end
  end

  // reset strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) reset_taken <= 1'b0;
    else reset_taken <= rst_do;
  end
endmodule : fst_flash_dev
`default_nettype wire

// File: rtl/fst_flash_host.sv
`timescale 1ns/10ps
`default_nettype none
module fst_flash_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  fst_link_if.host link
);
  import fst_pkg::*;

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [10:0] cmd_reg;
  logic [31:0] arg_reg;
  logic mode3_reg;
  logic access, mapped, busy;
  fst_host_state_e st_reg;

  assign access = psel & penable & pready;
  assign mapped = paddr == REG_CMD || paddr == REG_ARG || paddr == REG_CTRL
                  || paddr == REG_STATUS;
  assign busy = st_reg != H_IDLE;

  // one wait state, then answer
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          REG_CMD: prdata <= {21'h0, cmd_reg};
          REG_ARG: prdata <= arg_reg;
          REG_CTRL: prdata <= {29'h0, mode3_reg, 2'h0};
          REG_STATUS: prdata <= {31'h0, busy};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // setup registers, frozen while a frame runs
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cmd_reg <= 11'h000;
      arg_reg <= 32'h0000_0000;
      mode3_reg <= 1'b0;
    end else if (access && pwrite && !busy) begin
      if (paddr == REG_CMD) cmd_reg <= pwdata[10:0];
      if (paddr == REG_ARG) arg_reg <= pwdata;
      if (paddr == REG_CTRL) mode3_reg <= pwdata[CTRL_MODE3_BIT];
    end
  end

  // ---------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------
  logic go_cmd, go_jrst;
  logic [2:0] nbytes;
  logic [4:0] cnt_reg;
  logic [5:0] bits_reg;
  logic [38:0] sh_reg;
  logic [1:0] jidx_reg;
  logic half_done;

  assign go_cmd = access && pwrite && !busy && paddr == REG_CTRL && pwdata[CTRL_START_BIT];
  assign go_jrst = access && pwrite && !busy && paddr == REG_CTRL
                   && pwdata[CTRL_JRST_BIT] && !pwdata[CTRL_START_BIT];
  assign nbytes = cmd_reg[CMD_NBYTES_LSB +: 3] > MAX_ARG_BYTES ? MAX_ARG_BYTES
                  : cmd_reg[CMD_NBYTES_LSB +: 3];
  assign half_done = cnt_reg == 5'h00;

  // drive cs, sck and si from the clock divider
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_reg <= H_IDLE;
      cnt_reg <= 5'h00;
      bits_reg <= 6'h00;
      sh_reg <= '0;
      jidx_reg <= 2'h0;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.si <= 1'b0;
    end else begin
      cnt_reg <= half_done ? 5'(SCK_HALF_CYC - 1) : cnt_reg - 5'h01;
      unique case (st_reg)
        H_IDLE: begin
          link.cs_n <= 1'b1;
          cnt_reg <= 5'(SCK_HALF_CYC - 1);
          if (!go_cmd && !go_jrst) link.sck <= mode3_reg;
          if (go_cmd) begin
            st_reg <= H_LOW;
            link.cs_n <= 1'b0;
            link.sck <= 1'b0;
            link.si <= cmd_reg[7];
            sh_reg <= {cmd_reg[6:0], arg_reg};
            bits_reg <= 6'({nbytes, 3'h0} + 6'h07);
          end else if (go_jrst) begin
            st_reg <= J_LOW;
            jidx_reg <= 2'h0;
            link.cs_n <= 1'b0;
            link.sck <= mode3_reg; // RULE15
            link.si <= JEDEC_PATTERN[3]; // RULE17
          end
        end
        H_LOW: if (half_done) begin
          link.sck <= 1'b1;
          st_reg <= H_HIGH;
        end
        H_HIGH: if (half_done) begin
          if (bits_reg == 6'h00) begin
            link.sck <= mode3_reg;
            st_reg <= H_GAP;
          end else begin
            link.sck <= 1'b0;
            link.si <= sh_reg[38];
            sh_reg <= {sh_reg[37:0], 1'b0};
            bits_reg <= bits_reg - 6'h01;
            st_reg <= H_LOW;
          end
        end
        H_GAP: if (half_done) begin
          link.cs_n <= 1'b1;
          st_reg <= H_IDLE;
        end
        J_LOW: if (half_done) begin
          link.cs_n <= 1'b1;
          st_reg <= J_HIGH;
        end
        J_HIGH: if (half_done) begin
          if (jidx_reg == 2'h3) begin
            st_reg <= H_IDLE;
          end else begin
            jidx_reg <= jidx_reg + 2'h1;
            link.cs_n <= 1'b0;
            link.si <= JEDEC_PATTERN[2'h2 - jidx_reg]; // RULE17
            st_reg <= J_LOW;
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
endmodule : fst_flash_host
`default_nettype wire

// File: rtl/fst_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// serial link between host and flash
interface fst_link_if;
  logic cs_n;
  logic sck;
  logic si;
  modport host (output cs_n, output sck, output si);
  modport dev (input cs_n, input sck, input si);
endinterface : fst_link_if
`default_nettype wire

// File: rtl/fst_pkg.sv
package fst_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SUS_LAT_NS = 20000;
  localparam int SUS_CYC = (SUS_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam int TERM_LAT_NS = 15000;
  localparam int TERM_CYC = (TERM_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_TIME_NS = 100000;
  localparam int PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_TIME_NS = 400000;
  localparam int ERASE_CYC = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int NV_TIME_NS = 50000;
  localparam int NV_CYC = (NV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SCK_PERIOD_NS = 125;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS * CLK_MHZ / 2000;
  localparam int TMR_W = 20;
  // ---------------------------------------------------------------
  // opcodes and fixed values
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERASE = 8'h20;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_OTP = 8'h9b;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_TERM = 8'hf0;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_DEEP = 8'h79;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_QUAD = 8'h38;
  localparam logic [7:0] OP_GLOCK = 8'h7e;
  localparam logic [7:0] OP_GUNLOCK = 8'h98;
  localparam logic [7:0] OP_BUFWR = 8'h84;
  localparam logic [3:0] JEDEC_PATTERN = 4'h5;
  localparam logic [6:0] OTP_LAST_BYTE = 7'h7f;
  localparam logic PROTECT_DEFAULT = 1'b1;
  localparam logic [7:0] NV_STATUS_DEFAULT = 8'h00;
  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_JRST_BIT = 1;
  localparam int CTRL_MODE3_BIT = 2;
  localparam int CMD_NBYTES_LSB = 8;
  localparam logic [2:0] MAX_ARG_BYTES = 3'h4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OPS_IDLE, OPS_RUN, OPS_SUSPENDING, OPS_TERMINATING} fst_op_state_e;
  typedef enum logic [1:0] {KIND_PROG, KIND_ERASE, KIND_NV} fst_op_kind_e;
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_GAP, J_LOW, J_HIGH} fst_host_state_e;
endpackage : fst_pkg

// File: rtl/fst_sync.sv
`timescale 1ns/10ps
`default_nettype none
module fst_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // two-stage synchroniser
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : fst_sync
`default_nettype wire

// File: sim/fst_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fst_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link
  input wire logic cs_n,
  input wire logic si,
  // device status
  input wire logic busy,
  input wire logic program_suspended_flag,
  input wire logic program_error_flag,
  input wire logic erase_suspended_flag,
  input wire logic erase_error_flag,
  input wire logic [2:0] otp_lock_field,
  input wire logic [7:0] nv_status,
  input wire logic quad_mode,
  input wire logic global_protect,
  input wire logic reset_taken
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // si must hold for 8 cycles after cs falls, before any clock edge
  sequence s_sel;
    $fell(cs_n);
  endsequence
  a_si_held: assert property (s_sel |=> $stable(si) [*8])
    else $error("si moved early in a select pulse");
  a_prog_excl: assert property (!(program_suspended_flag && program_error_flag))
    else $error("program suspend and error both set");
  a_erase_excl: assert property (!(erase_suspended_flag && erase_error_flag))
    else $error("erase suspend and error both set");
  a_susp_idle: assert property ($rose(program_suspended_flag) |-> ##[0:1] !busy)
    else $error("busy stays up after suspend");
  a_term_idle: assert property ($rose(erase_error_flag) |-> ##[0:1] !busy)
    else $error("busy stays up after terminate");
  a_term_ignored: assert property (program_suspended_flag && $past(program_suspended_flag)
    |-> !$rose(program_error_flag))
    else $error("terminate taken after suspend done");
  a_lock_kept: assert property (&(otp_lock_field | ~$past(otp_lock_field)))
    else $error("otp lock bit fell");
  a_nv_kept: assert property (reset_taken |-> $stable(nv_status))
    else $error("nv status changed by reset");
  a_rst_defaults: assert property (reset_taken |=> !quad_mode && global_protect
    && !program_error_flag && !erase_error_flag)
    else $error("volatile state survived reset");
endmodule : fst_chk
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fst_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, busy, program_suspended_flag, program_error_flag, quad_mode;
  logic erase_suspended_flag, erase_error_flag, global_protect, reset_taken;
  logic [2:0] otp_lock_field;
  logic [7:0] nv_status, otp_rd_data;
  logic [7:0] fl;
  int num_errors = 0;
  int comparisons = 0;
  assign fl = {3'h0, busy, program_suspended_flag, program_error_flag, erase_suspended_flag,
    erase_error_flag};
  fst_link_if link ();
  // clock
  always #2.5 ref_clk = ~ref_clk;
  fst_flash_host fst_flash_host_inst (.ref_clk, .reset_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .link(link.host));
  fst_flash_dev #(.PROG_CYCLES(8000), .ERASE_CYCLES(8000), .NV_CYCLES(2000))
    fst_flash_dev_inst (.ref_clk, .reset_n, .link(link.dev), .hw_reset_pin_n(1'b1),
    .otp_rd_addr(9'h0ff), .otp_rd_data, .busy, .program_suspended_flag,
    .program_error_flag, .erase_suspended_flag, .erase_error_flag, .otp_lock_field,
    .nv_status, .quad_mode, .ultra_deep_power_down(), .global_protect, .buffer_byte(),
    .buffer_valid(), .reset_taken);
  fst_chk fst_chk_inst (.ref_clk, .reset_n, .cs_n(link.cs_n), .si(link.si), .busy,
    .program_suspended_flag, .program_error_flag, .erase_suspended_flag,
    .erase_error_flag, .otp_lock_field, .nv_status, .quad_mode, .global_protect,
    .reset_taken);
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // wait for link idle
  task automatic wait_idle;
    do apb(1'b0, REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : wait_idle
  // send one command frame
  task automatic cmd(input logic [7:0] op, input logic [2:0] nb, input logic [31:0] arg);
    apb(1'b1, REG_ARG, arg);
    apb(1'b1, REG_CMD, {21'h0, nb, op});
    apb(1'b1, REG_CTRL, 32'h1);
    wait_idle();
    repeat (8) @(posedge ref_clk);
  endtask : cmd
  // byte compare
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
  // tests
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    cmd(OP_PROG, 3'h4, 32'h000100a5);
    cmd(OP_SUSP, 3'h0, 32'h0);
    repeat (4100) @(posedge ref_clk);
    chk("flags", 8'h08, fl);
    cmd(OP_TERM, 3'h0, 32'h0);
    repeat (3100) @(posedge ref_clk);
    chk("flags", 8'h08, fl);
    cmd(OP_RESUME, 3'h0, 32'h0);
    chk("flags", 8'h10, fl);
    repeat (8100) @(posedge ref_clk);
    chk("flags", 8'h00, fl);
    $display("test suspend done");
    cmd(OP_ERASE, 3'h3, 32'h00200000);
    cmd(OP_SUSP, 3'h0, 32'h0);
    cmd(OP_TERM, 3'h0, 32'h0);
    repeat (3100) @(posedge ref_clk);
    chk("flags", 8'h01, fl);
    $display("test race done");
    cmd(OP_PROG, 3'h4, 32'h00020011);
    cmd(OP_TERM, 3'h0, 32'h0);
    repeat (3100) @(posedge ref_clk);
    chk("flags", 8'h05, fl);
    cmd(OP_OTP, 3'h4, 32'h0000ff3c);
    chk("flags", 8'h11, fl);
    cmd(OP_TERM, 3'h0, 32'h0);
    repeat (2100) @(posedge ref_clk);
    chk("flags", 8'h01, fl);
    chk("lock", 8'h01, {5'h0, otp_lock_field});
    chk("otp", 8'h3c, otp_rd_data);
    $display("test otp done");
    cmd(OP_WRSR, 3'h1, 32'h5a000000);
    cmd(OP_QUAD, 3'h0, 32'h0);
    apb(1'b1, REG_CTRL, 32'h2);
    wait_idle();
    repeat (2100) @(posedge ref_clk);
    chk("flags", 8'h00, fl);
    chk("lock", 8'h01, {5'h0, otp_lock_field});
    chk("nv", 8'h5a, nv_status);
    $display("test reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
